// ===== pkg/tbf_pkg.sv
// constants and types shared by the two-wire target front end
package tbf_pkg;

	// core clock period in ns
	localparam int CORE_PERIOD_NS = 8;

	// glitch_reject_width per rate, in ns; a pulse just under the width
	// can touch (width-1)/period+1 core edges, so one edge more must pass
	localparam int GLITCH_STD_NS = 100;
	localparam int GLITCH_FAST_NS = 50;
	localparam int GLITCH_STD_CYC =
		(GLITCH_STD_NS - 1) / CORE_PERIOD_NS + 2;
	localparam int GLITCH_FAST_CYC =
		(GLITCH_FAST_NS - 1) / CORE_PERIOD_NS + 2;
	localparam int FLT_W = 4;
	localparam logic [FLT_W-1:0] GLITCH_STD_LIM = FLT_W'(GLITCH_STD_CYC);
	localparam logic [FLT_W-1:0] GLITCH_FAST_LIM = FLT_W'(GLITCH_FAST_CYC);

	// power_up_ready_delay in ms; a longest time rounds down
	localparam real POWER_UP_READY_DELAY_MS = 0.35;
	localparam int POWER_UP_READY_CYC =
		int'($floor(POWER_UP_READY_DELAY_MS * 1.0e6 / CORE_PERIOD_NS));

	// nonvolatile_write_time in ms
	localparam real NONVOLATILE_WRITE_TIME_MS = 5.0;
	localparam int NONVOLATILE_WRITE_CYC =
		int'($floor(NONVOLATILE_WRITE_TIME_MS * 1.0e6 / CORE_PERIOD_NS));

	// bus_idle_gap the master keeps after a stop, in us
	localparam real BUS_IDLE_GAP_STD_US = 4.7;
	localparam real BUS_IDLE_GAP_FAST_US = 1.3;
	localparam real BUS_IDLE_GAP_FASTPLUS_US = 0.5;

	// address byte layout and byte framing
	localparam logic [3:0] DEV_TYPE = 4'ha;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] BIT_MSB = 3'h7;
	localparam logic [7:0] IDLE_BYTE = 8'hff;

	// index of each pin in the synchroniser vector
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_BIT = 2;
	localparam int PIN_SEL0 = 3;
	localparam int PIN_SEL1 = 4;
	localparam int PIN_SEL2 = 5;
	localparam int PIN_N = 6;

	// command state, gray along idle-addr-write and read-skip
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_WR = 3'h3,
		ST_RD = 3'h2,
		ST_SKIP = 3'h6
	} tbf_state_e;

endpackage : tbf_pkg

// ===== src/tbf_target.sv
// two-wire target front end: condition detect, shifter, receive fifo
//
// What this block does
// - target only; never drives clock or conditions
// - zero pulls data low, one releases it
// - sample on clock rise, drive on fall, open-drain
// - data change with clock high is a condition
// - start is data falling with clock high
// - ignore bus activity until a start
// - stop is data rising with clock high
// - ready for commands within power-up delay
// - reject narrow pulses on clock and data
// - power-on reset, brown-out forces reset
// - answer only when select bits match
// - acknowledge accepted byte in ninth clock
// - stop ending a write launches write cycle
// - no address acknowledge while write runs
`timescale 1ns/1ns

module tbf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// fill side
	input wire logic [WIDTH-1:0] i_in_data,
	input wire logic i_in_valid,
	output logic o_in_ready,
	// drain side
	output logic [WIDTH-1:0] o_out_data,
	output logic o_out_valid,
	input wire logic i_out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] cnt_r;

	wire push = i_in_valid && o_in_ready;
	wire pop = o_out_valid && i_out_ready;

	assign o_in_ready = (cnt_r != FULL_CNT);
	assign o_out_valid = (cnt_r != '0);
	assign o_out_data = mem_r[rd_ptr_r];

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

endmodule : tbf_fifo

module tbf_target #(
	parameter int PU_CYC = tbf_pkg::POWER_UP_READY_CYC,
	parameter int WR_CYC = tbf_pkg::NONVOLATILE_WRITE_CYC,
	parameter int FIFO_DEPTH = 8
) (
	// core clock and power-on reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// bus pins; the clock pin also clocks the sampling flop
	input wire logic i_scl,
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe,
	// select straps and rate setting
	input wire logic i_select_input_0,
	input wire logic i_select_input_1,
	input wire logic i_select_input_2,
	input wire logic i_fast_mode,
	// received bytes of write commands
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	// bytes to send on read commands
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	// status
	output logic o_ready,
	output logic o_busy,
	output logic o_write_launch,
	output logic o_cmd_active
);
	localparam int PUW = $clog2(PU_CYC + 1);
	localparam int WRW = $clog2(WR_CYC + 1);
	localparam logic [PUW-1:0] PU_LAST = PUW'(PU_CYC - 1);
	localparam logic [WRW-1:0] WR_LAST = WRW'(WR_CYC - 1);

	// link domain: data bit caught on the bus clock's own rise
	logic link_bit_r;

	always_ff @(posedge i_scl) begin
		link_bit_r <= i_sda_in;
	end

	// core domain: two-flop synchronisers for the bus and select pins and the link bit; the rate setting is not synchronised
	logic [tbf_pkg::PIN_N-1:0] pin_s1_r;
	logic [tbf_pkg::PIN_N-1:0] pin_s2_r;

	wire [tbf_pkg::PIN_N-1:0] pin_raw = {
		i_select_input_2,
		i_select_input_1,
		i_select_input_0,
		link_bit_r,
		i_sda_in,
		i_scl
	};

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			pin_s1_r <= '1;
			pin_s2_r <= '1;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	// glitch filter on clock and data: a level must hold lim cycles
	logic [1:0] flt_r;
	logic [1:0] flt_prev_r;
	logic [tbf_pkg::FLT_W-1:0] fcnt_r [2];

	wire [tbf_pkg::FLT_W-1:0] glitch_lim = i_fast_mode ?
		tbf_pkg::GLITCH_FAST_LIM : tbf_pkg::GLITCH_STD_LIM;

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			flt_r <= 2'h3;
			flt_prev_r <= 2'h3;
			fcnt_r[0] <= '0;
			fcnt_r[1] <= '0;
		end else begin
			flt_prev_r <= flt_r;
			for (int k = 0; k < 2; k++) begin
				if (pin_s2_r[k] == flt_r[k]) begin
					fcnt_r[k] <= '0;
				end else if (fcnt_r[k] == glitch_lim - 1'b1) begin
					flt_r[k] <= pin_s2_r[k];
					fcnt_r[k] <= '0;
				end else begin
					fcnt_r[k] <= fcnt_r[k] + 1'b1;
				end
			end
		end
	end

	// filtered events, and the data bit and select bits from the synchronisers
	wire scl_f = flt_r[tbf_pkg::PIN_SCL];
	wire scl_p = flt_prev_r[tbf_pkg::PIN_SCL];
	wire sda_f = flt_r[tbf_pkg::PIN_SDA];
	wire sda_p = flt_prev_r[tbf_pkg::PIN_SDA];
	wire scl_hold = scl_f && scl_p;
	wire scl_rise = scl_f && !scl_p;
	wire scl_fall = !scl_f && scl_p;
	wire start_cond = scl_hold && sda_p && !sda_f;
	wire stop_cond = scl_hold && !sda_p && sda_f;
	wire bit_in = pin_s2_r[tbf_pkg::PIN_BIT];
	wire [2:0] sel_bits = {
		pin_s2_r[tbf_pkg::PIN_SEL2],
		pin_s2_r[tbf_pkg::PIN_SEL1],
		pin_s2_r[tbf_pkg::PIN_SEL0]
	};

	// power-up ready delay after reset release
	logic [PUW-1:0] pu_cnt_r;
	logic ready_r;

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			pu_cnt_r <= '0;
			ready_r <= 1'b0;
		end else if (!ready_r) begin
			if (pu_cnt_r == PU_LAST) begin
				ready_r <= 1'b1;
			end else begin
				pu_cnt_r <= pu_cnt_r + 1'b1;
			end
		end
	end

	// write cycle timer started by a stop that ends a write
	logic [WRW-1:0] wr_cnt_r;
	logic busy_r;
	logic launch_r;

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			wr_cnt_r <= '0;
			busy_r <= 1'b0;
		end else if (launch_r) begin
			wr_cnt_r <= '0;
			busy_r <= 1'b1;
		end else if (busy_r) begin
			if (wr_cnt_r == WR_LAST) begin
				busy_r <= 1'b0;
			end else begin
				wr_cnt_r <= wr_cnt_r + 1'b1;
			end
		end
	end

	// command sequencer
	tbf_pkg::tbf_state_e state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] sh_r;
	logic [7:0] tx_sh_r;
	logic rd_first_r;
	logic wrote_r;
	logic oe_r;
	logic push_r;
	logic tx_take_r;
	logic fifo_in_ready;

	wire addr_hit = (sh_r[7:4] == tbf_pkg::DEV_TYPE) &&
		(sh_r[3:1] == sel_bits);
	wire ack_slot = (bit_cnt_r == tbf_pkg::BYTE_BITS);
	wire [2:0] tx_idx = tbf_pkg::BIT_MSB - bit_cnt_r[2:0];
	wire [7:0] tx_next = i_tx_valid ? i_tx_data : tbf_pkg::IDLE_BYTE;

	always_ff @(posedge i_core_clk) begin
		push_r <= 1'b0;
		launch_r <= 1'b0;
		tx_take_r <= 1'b0;
		if (!i_resetn) begin
			state_r <= tbf_pkg::ST_IDLE;
			bit_cnt_r <= '0;
			sh_r <= '0;
			tx_sh_r <= tbf_pkg::IDLE_BYTE;
			rd_first_r <= 1'b0;
			wrote_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (start_cond && ready_r) begin
			state_r <= tbf_pkg::ST_ADDR;
			bit_cnt_r <= '0;
			wrote_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (stop_cond) begin
			launch_r <= wrote_r;
			state_r <= tbf_pkg::ST_IDLE;
			wrote_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (state_r != tbf_pkg::ST_IDLE) begin
			if (scl_rise) begin
				if (ack_slot) begin
					bit_cnt_r <= '0;
					if (state_r == tbf_pkg::ST_RD) begin
						// master low in the ack slot asks for another byte
						if (rd_first_r || !bit_in) begin
							tx_sh_r <= tx_next;
							tx_take_r <= i_tx_valid;
							rd_first_r <= 1'b0;
						end else begin
							state_r <= tbf_pkg::ST_SKIP;
						end
					end
				end else begin
					sh_r <= {sh_r[6:0], bit_in};
					bit_cnt_r <= bit_cnt_r + 1'b1;
				end
			end else if (scl_fall) begin
				if (ack_slot) begin
					case (state_r)
						tbf_pkg::ST_ADDR: begin
							if (addr_hit && !busy_r) begin
								oe_r <= 1'b1;
								rd_first_r <= 1'b1;
								state_r <= sh_r[0] ? tbf_pkg::ST_RD : tbf_pkg::ST_WR;
							end else begin
								state_r <= tbf_pkg::ST_SKIP;
							end
						end
						tbf_pkg::ST_WR: begin
							if (fifo_in_ready) begin
								oe_r <= 1'b1;
								push_r <= 1'b1;
								wrote_r <= 1'b1;
							end else begin
								state_r <= tbf_pkg::ST_SKIP;
							end
						end
						default: begin
							oe_r <= 1'b0;
						end
					endcase
				end else if (state_r == tbf_pkg::ST_RD) begin
					oe_r <= !tx_sh_r[tx_idx];
				end else begin
					oe_r <= 1'b0;
				end
			end
		end
	end

	// received bytes wait here for the consumer
	tbf_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.i_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_in_data(sh_r),
		.i_in_valid(push_r),
		.o_in_ready(fifo_in_ready),
		.o_out_data(o_rx_data),
		.o_out_valid(o_rx_valid),
		.i_out_ready(i_rx_ready)
	);

	// data pin is open-drain; the clock pin is never driven
	assign o_sda_out = 1'b0;
	assign o_sda_oe = oe_r;
	assign o_tx_ready = tx_take_r;
	assign o_ready = ready_r;
	assign o_busy = busy_r;
	assign o_write_launch = launch_r;
	assign o_cmd_active = (state_r != tbf_pkg::ST_IDLE);

endmodule : tbf_target

// ===== testbench/tb.sv
// self-checking bench for the two-wire target front end
`timescale 1ns/1ns
module tb;
	localparam int PU = 300;
	logic clk, rstn, fast, rx_rdy, tx_vld, ack, m_oe, scl;
	logic rx_v, tx_r, rdy, busy, lnch, act, oe, so;
	logic [2:0] sel;
	logic [7:0] tx_d, rx_d, q;
	int n_mismatch, n_checks, cnt, nl, na, nt;
	logic [15:0] rows [4] = '{16'h5aa5, 16'ha43c, 16'h7d00, 16'h80ff};
	wire sda = !m_oe && !(oe && !so);
	tbf_target #(.PU_CYC(PU), .WR_CYC(2000)) u_dut (.i_core_clk(clk),
		.i_resetn(rstn), .i_scl(scl), .i_sda_in(sda), .o_sda_out(so),
		.o_sda_oe(oe), .i_select_input_0(sel[0]),
		.i_select_input_1(sel[1]), .i_select_input_2(sel[2]),
		.i_fast_mode(fast), .o_rx_data(rx_d), .o_rx_valid(rx_v),
		.i_rx_ready(rx_rdy), .i_tx_data(tx_d), .i_tx_valid(tx_vld),
		.o_tx_ready(tx_r), .o_ready(rdy), .o_busy(busy),
		.o_write_launch(lnch), .o_cmd_active(act));
	tbf_master u_mst (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (lnch === 1'b1) nl++;
		if (act === 1'b1) na++;
		if (tx_r === 1'b1) nt++;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic give_verdict;
		if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic hold;
		@(posedge clk) rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
	endtask : hold
	task automatic addr(input logic [2:0] s, input logic rd, input logic e);
		u_mst.start();
		u_mst.xfer({4'ha, s, rd}, 1'b1, q, ack);
		chk(8'(ack), 8'(e));
	endtask : addr
	task automatic idle;
		for (int k = 0; k < 2100 && busy !== 1'b0; k++) @(posedge clk);
		chk(8'(busy), 8'h0);
	endtask : idle
	initial begin
		rstn = 1'b0;
		fast = 1'b0;
		sel = 3'h0;
		rx_rdy = 1'b0;
		tx_vld = 1'b0;
		tx_d = 8'h0;
		hold();
		for (cnt = 0; rdy !== 1'b1 && cnt < PU + 9; cnt++) @(posedge clk);
		chk(8'(cnt >= PU - 1 && cnt <= PU + 2), 8'h1);
		foreach (rows[i]) begin
			@(posedge clk) {fast, sel} <= rows[i][15:12];
			addr(rows[i][11:9], 1'b0, rows[i][8]);
			if (!rows[i][8]) begin
				u_mst.xfer(rows[i][7:0], 1'b1, q, ack);
				chk(8'(ack), 8'h0);
				chk(rx_d, rows[i][7:0]);
				@(posedge clk) rx_rdy <= 1'b1;
				@(posedge clk) rx_rdy <= 1'b0;
			end
			cnt = nl;
			u_mst.stop();
			chk(8'(nl - cnt), 8'(!rows[i][8]));
			chk(8'(act), 8'h0);
			idle();
		end
		@(posedge clk) sel <= 3'h3;
		addr(3'h3, 1'b0, 1'b0);
		chk(8'(act), 8'h1);
		for (int i = 0; i < 9; i++) begin
			u_mst.xfer(8'h10 + 8'(i), 1'b1, q, ack);
			chk(8'(ack), 8'(i == 8));
		end
		u_mst.stop();
		addr(3'h3, 1'b0, 1'b1);
		u_mst.stop();
		@(posedge clk) rx_rdy <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			#1 chk(rx_d, 8'h10 + 8'(i));
			@(posedge clk);
		end
		rx_rdy <= 1'b0;
		#1 chk(8'(rx_v), 8'h0);
		idle();
		@(posedge clk) begin
			tx_d <= 8'h96;
			tx_vld <= 1'b1;
		end
		addr(3'h3, 1'b0, 1'b0);
		addr(3'h3, 1'b1, 1'b0);
		for (int i = 0; i < 2; i++) begin
			u_mst.xfer(8'hff, 1'(i), q, ack);
			chk(q, 8'h96);
		end
		u_mst.stop();
		chk(8'(busy), 8'h0);
		chk(8'(nt), 8'h2);
		na = 0;
		u_mst.glitch();
		repeat (30) @(posedge clk);
		chk(8'(na), 8'h0);
		hold();
		#1 chk(8'(rdy), 8'h0);
		addr(3'h3, 1'b0, 1'b1);
		u_mst.stop();
		give_verdict();
	end
	initial begin
		#760000;
		n_mismatch++;
		give_verdict();
	end
endmodule : tb

// ===== testbench/tbf_master.sv
// two-wire bus master model; clock stands high outside frames
`timescale 1ns/1ns
module tbf_master (
	// bus side
	output logic o_scl,
	output logic o_sda_oe,
	input wire logic i_sda
);
	// quarter bit: 1 us bit time keeps within the fastest rate's limits
	localparam int H = 250;
	// idle gap after a stop: the longest of the three rates
	localparam int GAP = 4700;
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task automatic start;
		#H o_sda_oe = 1'b0;
		#(2*H) o_scl = 1'b1;
		#(2*H) o_sda_oe = 1'b1;
		#(2*H) o_scl = 1'b0;
	endtask : start
	task automatic stop;
		#H o_sda_oe = 1'b1;
		#H o_scl = 1'b1;
		#(2*H) o_sda_oe = 1'b0;
		#GAP;
	endtask : stop
	// data moves only mid-low
	task automatic bitx(input logic b, output logic r);
		#H o_sda_oe = !b;
		#H o_scl = 1'b1;
		#H r = i_sda;
		#H o_scl = 1'b0;
	endtask : bitx
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(a, k);
	endtask : xfer
	task automatic glitch;
		o_sda_oe = 1'b1;
		#40 o_sda_oe = 1'b0;
	endtask : glitch
endmodule : tbf_master

// ===== testbench/tbf_props.sv
// assertions on the two-wire target front end ports
`timescale 1ns/1ns
module tbf_props (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// bus pins
	input wire logic i_scl,
	input wire logic i_sda_in,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	// status
	input wire logic o_ready,
	input wire logic o_busy,
	input wire logic o_write_launch,
	input wire logic o_cmd_active
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	property p_od;
		o_sda_out == 1'b0 && (!o_sda_oe || !i_sda_in);
	endproperty
	a_od: assert property (p_od) else $error("sda high");
	property p_quiet; o_sda_oe |-> $past(o_cmd_active); endproperty
	a_quiet: assert property (p_quiet) else $error("idle oe");
	property p_rdy; !o_ready |-> !o_cmd_active; endproperty
	a_rdy: assert property (p_rdy) else $error("early cmd");
	property p_lnch; o_write_launch |=> o_busy && !o_write_launch; endproperty
	a_lnch: assert property (p_lnch) else $error("launch");
	property p_busy; $rose(o_busy) |-> $past(o_write_launch); endproperty
	a_busy: assert property (p_busy) else $error("busy");
	property p_stop;
		o_write_launch |-> i_scl && i_sda_in && $past(i_sda_in, 8);
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_fall; $rose(o_sda_oe) |-> !i_scl; endproperty
	a_fall: assert property (p_fall) else $error("oe edge");
	property p_start;
		$rose(o_cmd_active) |-> i_scl && !i_sda_in && $past(i_scl, 8);
	endproperty
	a_start: assert property (p_start) else $error("start");
	property p_bo;
		disable iff (1'b0) !i_resetn |=> !o_ready && !o_sda_oe && !o_busy;
	endproperty
	a_bo: assert property (p_bo) else $error("reset");
	c_lnch: cover property (o_write_launch);
	c_oe: cover property ($rose(o_sda_oe));
	c_busy: cover property ($fell(o_busy));
endmodule : tbf_props

bind tbf_target tbf_props u_props (.i_core_clk(i_core_clk),
	.i_resetn(i_resetn), .i_scl(i_scl), .i_sda_in(i_sda_in),
	.o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_ready(o_ready),
	.o_busy(o_busy), .o_write_launch(o_write_launch),
	.o_cmd_active(o_cmd_active));
